// ===== rtl/mba_arb_pick.sv
`timescale 1ns/1ps
`include "mba_consts.svh"

// Picks the next bus owner from the request lines seen this cycle.
module mba_arb_pick (
    input  wire mba_pkg::mba_lines_t i_req,
    input  wire mba_pkg::mba_id_t    i_last,
    input  wire logic                i_rotate,
    output mba_pkg::mba_id_t         o_winner
);
    import mba_pkg::*;

    int ln;

    always_comb begin
        ln       = 0;
        o_winner = `MBA_NO_OWNER;
        // Descending walk so that the highest-priority requester is written last.
        for (int j = `MBA_NUM_PROC; j >= 1; j--) begin
            if (i_rotate && i_last != `MBA_NO_OWNER) begin
                ln = ((int'(i_last) - 1 + j) % `MBA_NUM_PROC) + 1;
            end else begin
                ln = j;
            end
            if (i_req[ln - 1]) begin
                o_winner = mba_id_t'(ln);
            end
        end
    end

endmodule : mba_arb_pick

// ===== rtl/mba_dev_end.sv
// Functional notes
// - Port device raises DMA request for its channel.
// - Grant means DMA transfer starts next cycle.
// - Only the bus master drives DMA grants.
// - Drive own request line only, watch others.
// - ID n selects request line n.
// - Single-processor systems use ID 000 or 001.
// - Master indicator high only while owning bus.
// - ID 000 holds master indicator high.
// - Select high rotates priority, low fixes it.
// - Priority select identical and synchronous everywhere.
// - IDs change only during reset.
// - Priority access suspends DMA, hands bus over.
// - Host request beats processors; master grants host.
`timescale 1ns/1ps
`include "mba_consts.svh"

module mba_dev_end (
    input  wire logic             i_sys_clk,
    input  wire logic             i_sys_rst,
    mba_bus_if.dev_mp             bus,
    input  wire mba_pkg::mba_id_t i_proc_id,
    input  wire logic             i_bus_want,
    input  wire logic             i_pa_want,
    output logic                  o_master_indicator,
    output logic                  o_bus_drive_en,
    output logic                  o_host_owns,
    output mba_pkg::mba_dma_t     o_dma_start
);
    import mba_pkg::*;

    localparam mba_dev_state_t RESET_STATE = '{
        owner:     `MBA_NO_OWNER,
        master:    1'b0,
        hst:       MBA_HS_RUN,
        float_cnt: 2'h0,
        grant:     '0,
        go:        '0
    };

    mba_dev_state_t s_reg;
    mba_dev_state_t s_next;
    mba_lines_t     my_line;
    logic           single;
    logic           pa_other;
    logic           want_eff;
    logic           owner_holds;
    logic           dma_open;
    mba_id_t        winner;
    mba_dev_state_t host_nx;

    // Bus outputs are live only on the owner, and not while the host is taking over.
    // The DMA grants use the same window, so they stop as soon as the bus is handed on.
    function automatic logic drives_bus(input mba_dev_state_t st);
        return st.master && st.hst == MBA_HS_RUN;
    endfunction : drives_bus

    // The owner moves only when the holder has let go, no host is asking and someone
    // else is requesting; with no requests the last holder stays parked on the bus.
    function automatic mba_id_t owner_step(input mba_id_t owner,
                                           input logic    holds,
                                           input logic    host_req,
                                           input mba_id_t pick);
        mba_id_t nx;
        nx = owner;
        if (!host_req && !holds && pick != `MBA_NO_OWNER) begin
            nx = pick;
        end
        return nx;
    endfunction : owner_step

    // Mastership follows the shared owner code; a lone processor is always master.
    function automatic logic master_of(input mba_id_t owner, input mba_id_t id);
        logic m;
        if (id == `MBA_ID_SINGLE) begin
            m = 1'b1;
        end else begin
            m = mba_line_of(id) != '0 && owner == id;
        end
        return m;
    endfunction : master_of

    // A master that sees the host request lets the grant float for a fixed number of
    // input clocks before granting, so two drivers never fight over the grant line.
    // The host then keeps the bus until it lets go of its request.
    function automatic mba_dev_state_t host_step(input mba_dev_state_t st,
                                                 input logic           host_req);
        mba_dev_state_t nx;
        nx = st;
        case (st.hst)
            MBA_HS_RUN: begin
                if (host_req && st.master) begin
                    nx.hst       = MBA_HS_FLOAT;
                    nx.float_cnt = 2'h0;
                end
            end
            MBA_HS_FLOAT: begin
                nx.float_cnt = st.float_cnt + 2'h1;
                if (!host_req) begin
                    nx.hst = MBA_HS_RUN;
                end else if (nx.float_cnt >= 2'(`MBA_HBG_FLOAT_CK)) begin
                    nx.hst = MBA_HS_HOST;
                end
            end
            MBA_HS_HOST: begin
                if (!host_req) begin
                    nx.hst = MBA_HS_RUN;
                end
            end
            default: begin
                nx.hst = MBA_HS_RUN;
            end
        endcase
        return nx;
    endfunction : host_step

    // A channel is granted for one cycle and then skipped for one, which gives the
    // far end a cycle to clear its request before it can be seen again.
    function automatic mba_dma_t grant_of(input mba_dma_t req, input mba_dma_t last);
        return req & ~last;
    endfunction : grant_of

    // The ID inputs are wiring, so the own line is decoded every cycle.
    assign my_line = mba_line_of(i_proc_id);
    assign single  = i_proc_id == `MBA_ID_SINGLE;

    // A priority-access request seen from another party, not from this end.
    assign pa_other = bus.pa && !bus.pa_dev_oe;

    // The master drops its request when a slave claims priority access.
    assign want_eff = i_bus_want && !(s_reg.master && pa_other);

    // The owner keeps the bus while its own line stays asserted.
    assign owner_holds = (bus.br & mba_line_of(s_reg.owner)) != '0;

    // DMA may be granted only while this end owns the bus and no one overrides.
    assign dma_open = drives_bus(s_reg) && !bus.host_bus_request && !pa_other;

    // Every processor feeds the same lines and owner into the same picker.
    mba_arb_pick u_pick (
        .i_req    (bus.br),
        .i_last   (s_reg.owner),
        .i_rotate (bus.rotating_priority_select),
        .o_winner (winner)
    );

    always_comb begin
        s_next = s_reg;

        // Every processor sees the same lines and owner, so all reach the same owner.
        s_next.owner  = owner_step(s_reg.owner, owner_holds, bus.host_bus_request, winner);
        s_next.master = master_of(s_next.owner, i_proc_id);

        // The host handover only moves the host state and its float counter.
        host_nx          = host_step(s_reg, bus.host_bus_request);
        s_next.hst       = host_nx.hst;
        s_next.float_cnt = host_nx.float_cnt;

        // A grant lasts one cycle and the transfer starts in the next one.
        if (dma_open) begin
            s_next.grant = grant_of(bus.dma_req, s_reg.grant);
        end else begin
            s_next.grant = '0;
        end
        s_next.go = s_reg.grant;
    end

    // All state moves together on the one clock; reset leaves the bus with no owner.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            s_reg <= RESET_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Request line: only the own line is ever enabled, the others are inputs.
    always_comb begin
        bus.br_dev_oe = single ? '0 : my_line;
        bus.br_dev_o  = want_eff ? my_line : '0;
    end

    // Grant lines are enabled only on the master, and float everywhere else.
    always_comb begin
        bus.dma_grant_oe = s_reg.master;
        bus.dma_grant_o  = s_reg.grant;
    end

    // A slave claims priority access as an open-drain pull of the shared line.
    always_comb begin
        bus.pa_dev_oe = i_pa_want && !s_reg.master;
        bus.pa_dev_o  = bus.pa_dev_oe;
    end

    // The master drives the host grant, floating it while the host is waiting.
    always_comb begin
        bus.hbg_oe = s_reg.master && s_reg.hst != MBA_HS_FLOAT;
        bus.hbg_o  = s_reg.hst == MBA_HS_HOST;
    end

    // Outputs come straight from the registered state, so they cannot glitch.
    always_comb begin
        o_master_indicator = s_reg.master;
        o_bus_drive_en     = drives_bus(s_reg);
        o_host_owns        = s_reg.hst == MBA_HS_HOST;
        o_dma_start        = s_reg.go;
    end

endmodule : mba_dev_end

// ===== rtl/mba_sys_end.sv
`timescale 1ns/1ps

// Far side: peer processors' request lines, port DMA devices, a host, and the
// system-wide priority select.
module mba_sys_end (
    input  wire logic               i_sys_clk,
    input  wire logic               i_sys_rst,
    mba_bus_if.sys_mp               bus,
    input  wire mba_pkg::mba_id_t   i_dev_id,
    input  wire mba_pkg::mba_lines_t i_peer_req,
    input  wire mba_pkg::mba_dma_t  i_dma_req,
    input  wire logic               i_pa_req,
    input  wire logic               i_host_req,
    input  wire logic               i_rotating_priority_select,
    output mba_pkg::mba_dma_t       o_dma_go,
    output logic                    o_host_granted
);
    import mba_pkg::*;

    localparam mba_sys_state_t RESET_STATE = '{
        peer_req:     '0,
        dma_pend:     '0,
        pa_req:       1'b0,
        host_req:     1'b0,
        rotating_priority_select:         1'b0,
        dma_go:       '0,
        host_granted: 1'b0
    };

    mba_sys_state_t s_reg;
    mba_sys_state_t s_next;

    always_comb begin
        s_next = s_reg;
        // Peers never touch the line that belongs to the device end.
        s_next.peer_req = i_peer_req & ~mba_line_of(i_dev_id);
        // A DMA request is held until its grant; a new pulse beats the clear.
        s_next.dma_pend = (s_reg.dma_pend & ~bus.dma_grant) | i_dma_req;
        s_next.dma_go   = bus.dma_grant;
        s_next.pa_req   = i_pa_req;
        s_next.host_req = i_host_req;
        // One register feeds every processor, so a change lands in one cycle.
        s_next.rotating_priority_select         = i_rotating_priority_select;
        s_next.host_granted = bus.host_bus_grant;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            s_reg <= RESET_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    always_comb begin
        bus.br_sys_oe = ~mba_line_of(i_dev_id);
        bus.br_sys_o  = s_reg.peer_req;
        bus.dma_req   = s_reg.dma_pend;
        bus.pa_sys_oe = s_reg.pa_req;
        bus.pa_sys_o  = s_reg.pa_req;
        bus.host_bus_request       = s_reg.host_req;
        bus.rotating_priority_select      = s_reg.rotating_priority_select;
    end

    always_comb begin
        o_dma_go       = s_reg.dma_go;
        o_host_granted = s_reg.host_granted;
    end

endmodule : mba_sys_end

// ===== shared/mba_bus_if.sv
`timescale 1ns/1ps

// Signals are asserted high; an undriven shared line reads as deasserted.
interface mba_bus_if;
    import mba_pkg::*;

    mba_lines_t br_dev_o;
    mba_lines_t br_dev_oe;
    mba_lines_t br_sys_o;
    mba_lines_t br_sys_oe;
    mba_lines_t br;
    mba_dma_t   dma_req;
    mba_dma_t   dma_grant_o;
    logic       dma_grant_oe;
    mba_dma_t   dma_grant;
    logic       pa_dev_o;
    logic       pa_dev_oe;
    logic       pa_sys_o;
    logic       pa_sys_oe;
    logic       pa;
    logic       host_bus_request;
    logic       hbg_o;
    logic       hbg_oe;
    logic       host_bus_grant;
    logic       rotating_priority_select;

    assign br        = (br_dev_o & br_dev_oe) | (br_sys_o & br_sys_oe);
    assign dma_grant = dma_grant_oe ? dma_grant_o : '0;
    assign pa        = (pa_dev_o & pa_dev_oe) | (pa_sys_o & pa_sys_oe);
    assign host_bus_grant       = hbg_o & hbg_oe;

    modport dev_mp (
        output br_dev_o, br_dev_oe, dma_grant_o, dma_grant_oe, pa_dev_o, pa_dev_oe,
        output hbg_o, hbg_oe,
        input  br, dma_req, pa, host_bus_request, rotating_priority_select
    );

    modport sys_mp (
        output br_sys_o, br_sys_oe, dma_req, pa_sys_o, pa_sys_oe, host_bus_request, rotating_priority_select,
        input  br, dma_grant, pa, host_bus_grant
    );

endinterface : mba_bus_if

// ===== shared/mba_consts.svh
`ifndef MBA_CONSTS_SVH
`define MBA_CONSTS_SVH

// Number of processors that share the external bus.
`define MBA_NUM_PROC     6
// Width of the processor ID inputs.
`define MBA_ID_W         3
// Processor ID that marks a single-processor system.
`define MBA_ID_SINGLE    3'h0
// Owner code meaning that no request line has won the bus yet.
`define MBA_NO_OWNER     3'h0
// Number of DMA request and grant channels on the external port.
`define MBA_DMA_CH       2
// Index of the channel 11 and channel 12 pair within the DMA vectors.
`define MBA_DMA_CH11     0
`define MBA_DMA_CH12     1
// Input clock cycles for which the host grant floats before it is given.
`define MBA_HBG_FLOAT_CK 1

`endif

// ===== shared/mba_pkg.sv
`include "mba_consts.svh"

package mba_pkg;

    typedef logic [`MBA_ID_W-1:0]     mba_id_t;
    typedef logic [`MBA_NUM_PROC-1:0] mba_lines_t;
    typedef logic [`MBA_DMA_CH-1:0]   mba_dma_t;

    typedef enum logic [1:0] {
        MBA_HS_RUN,
        MBA_HS_FLOAT,
        MBA_HS_HOST
    } mba_host_st_t;

    typedef struct packed {
        mba_id_t      owner;
        logic         master;
        mba_host_st_t hst;
        logic [1:0]   float_cnt;
        mba_dma_t     grant;
        mba_dma_t     go;
    } mba_dev_state_t;

    typedef struct packed {
        mba_lines_t peer_req;
        mba_dma_t   dma_pend;
        logic       pa_req;
        logic       host_req;
        logic       rotating_priority_select;
        mba_dma_t   dma_go;
        logic       host_granted;
    } mba_sys_state_t;

    // One-hot request line of a processor ID; IDs 0 and 7 select no line.
    function automatic mba_lines_t mba_line_of(input mba_id_t id);
        mba_lines_t line;
        line = '0;
        if (id != `MBA_ID_SINGLE && int'(id) <= `MBA_NUM_PROC) begin
            line[int'(id) - 1] = 1'b1;
        end
        return line;
    endfunction : mba_line_of

endpackage : mba_pkg

// ===== testbench/mba_bus_asserts.sv
`timescale 1ns/1ps

module mba_bus_asserts (
    input logic                i_sys_clk,
    input logic                i_sys_rst,
    input mba_pkg::mba_id_t    i_proc_id,
    input mba_pkg::mba_lines_t br_dev_o,
    input mba_pkg::mba_lines_t br_dev_oe,
    input mba_pkg::mba_dma_t   dma_req,
    input logic                dma_grant_oe,
    input mba_pkg::mba_dma_t   dma_grant,
    input logic                pa_sys_o,
    input logic                pa_sys_oe,
    input logic                host_bus_request,
    input logic                host_bus_grant
);
    import mba_pkg::*;
    mba_lines_t id_line;
    logic       pa_far;
    assign id_line = (i_proc_id != 3'h0 && i_proc_id <= 3'h6) ?
                     6'h01 << (i_proc_id - 3'h1) : 6'h00;
    assign pa_far = pa_sys_o && pa_sys_oe;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // The host grant stays low for two cycles, the request cycle and one float cycle, before it is given.
    sequence s_float; !host_bus_grant [*2]; endsequence
    sequence s_given; host_bus_grant; endsequence
    AST_ONE_LINE: assert property ($onehot0(br_dev_oe))
        else $error("more than one request line enabled");
    AST_ID_LINE: assert property (br_dev_oe == id_line)
        else $error("request line does not match the id");
    AST_GRANT_REQ: assert property ((dma_grant & ~$past(dma_req)) == 2'h0)
        else $error("grant without a request");
    AST_GRANT_MASTER: assert property (dma_grant != 2'h0 |-> $past(dma_grant_oe))
        else $error("grant from a non-master");
    AST_GRANT_PULSE: assert property (
        dma_grant != 2'h0 |=> (dma_grant & $past(dma_grant)) == 2'h0)
        else $error("grant longer than one cycle");
    AST_PA_BLOCKS: assert property (pa_far |=> dma_grant == 2'h0)
        else $error("grant during priority access");
    AST_PA_DROP: assert property (
        pa_far && dma_grant_oe |-> (br_dev_o & br_dev_oe) == 6'h00)
        else $error("master kept its request during priority access");
    AST_HOST_SEQ: assert property ($rose(host_bus_request) && dma_grant_oe |-> s_float ##1 s_given)
        else $error("host grant timing wrong");
    AST_HOST_HOLD: assert property (host_bus_grant && host_bus_request |=> host_bus_grant)
        else $error("host grant dropped while requested");
    AST_HOST_DROP: assert property ($fell(host_bus_request) |=> !host_bus_grant)
        else $error("host grant kept after release");
    AST_SINGLE: assert property (
        i_proc_id == 3'h0 && !$past(i_sys_rst) && !host_bus_request && !host_bus_grant |-> dma_grant_oe)
        else $error("single processor not master");
endmodule : mba_bus_asserts

// ===== testbench/test_multiproc_bus_arbitration.sv
`timescale 1ns/1ps

module test_multiproc_bus_arbitration;
    import mba_pkg::*;
    logic       i_sys_clk = 1'b0;
    logic       i_sys_rst = 1'b1;
    mba_id_t    proc_id   = 3'h1;
    logic       bus_want  = 1'b0;
    logic       pa_want   = 1'b0;
    mba_lines_t peer_req  = 6'h00;
    mba_dma_t   dma_req   = 2'h0;
    logic       pa_req    = 1'b0;
    logic       host_req  = 1'b0;
    logic       rotating_priority_select      = 1'b0;
    logic       master, drive_en, host_owns, host_granted;
    mba_dma_t   dma_start, dma_go, exp_dma;
    mba_dma_t   qd[$];
    int         miscompares = 0;
    int         comparisons = 0;
    int         cycles = 0;
    int         seed = 32'h2e72b174;

    mba_bus_if bus ();
    mba_dev_end u_mba_dev_end (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .bus(bus),
        .i_proc_id(proc_id), .i_bus_want(bus_want), .i_pa_want(pa_want),
        .o_master_indicator(master), .o_bus_drive_en(drive_en), .o_host_owns(host_owns),
        .o_dma_start(dma_start));
    mba_sys_end u_mba_sys_end (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .bus(bus),
        .i_dev_id(proc_id), .i_peer_req(peer_req), .i_dma_req(dma_req), .i_pa_req(pa_req),
        .i_host_req(host_req), .i_rotating_priority_select(rotating_priority_select), .o_dma_go(dma_go),
        .o_host_granted(host_granted));
    mba_bus_asserts u_mba_bus_asserts (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .i_proc_id(proc_id), .br_dev_o(bus.br_dev_o), .br_dev_oe(bus.br_dev_oe),
        .dma_req(bus.dma_req), .dma_grant_oe(bus.dma_grant_oe), .dma_grant(bus.dma_grant),
        .pa_sys_o(bus.pa_sys_o), .pa_sys_oe(bus.pa_sys_oe), .host_bus_request(bus.host_bus_request), .host_bus_grant(bus.host_bus_grant));

    initial begin
        forever begin
            #5 i_sys_clk = ~i_sys_clk;
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic tick(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask : tick

    task automatic restart(input mba_id_t id, input logic rot, input string prev);
        $display("test %s done at %0t", prev, $time);
        i_sys_rst = 1'b1;
        proc_id = id;
        rotating_priority_select = rot;
        bus_want = 1'b0;
        peer_req = 6'h00;
        tick(16);
        i_sys_rst = 1'b0;
    endtask : restart

    // Each DMA start is matched against the oldest expected grant.
    always @(negedge i_sys_clk) begin
        cycles++;
        if (cycles > 4000) begin
            miscompares++;
            report_and_stop();
        end
        if (!i_sys_rst && dma_go != 2'h0) begin
            exp_dma = (qd.size() == 0) ? 2'h0 : qd.pop_front();
            cmp_val(dma_go, exp_dma);
            cmp_val(dma_start, exp_dma);
        end
    end

    initial begin
        for (int id = 1; id <= 6; id++) begin
            restart(id[2:0], 1'b0, "reset");
            cmp_val(master, 1'b0);
            bus_want = 1'b1;
            tick(3);
            cmp_val(bus.br_dev_oe, 8'h01 << (id - 1));
            cmp_val(bus.br, 8'h01 << (id - 1));
            cmp_val({master, drive_en}, 8'h03);
        end
        restart(3'h0, 1'b0, "ids");
        tick(2);
        cmp_val({master, bus.br_dev_oe}, 8'h40);
        for (int r = 0; r < 2; r++) begin
            restart(3'h3, r[0], "order");
            peer_req = 6'h02;
            tick(4);
            peer_req = 6'h03;
            bus_want = 1'b1;
            tick(4);
            cmp_val(master, 1'b0);
            peer_req = 6'h01;
            tick(4);
            cmp_val(master, r[0]);
        end
        for (int k = 0; k < 6; k++) begin
            restart(3'h4, 1'b0, "priority");
            peer_req = 6'($random(seed));
            // Peer lines pass a far-end register, so the own request waits one cycle.
            tick(1);
            bus_want = 1'b1;
            tick(4);
            cmp_val(master, peer_req[2:0] == 3'h0);
        end
        restart(3'h2, 1'b0, "random");
        dma_req = 2'h3;
        pa_want = 1'b1;
        tick(1);
        dma_req = 2'h0;
        tick(5);
        cmp_val({bus.pa, bus.dma_grant}, 8'h04);
        pa_want = 1'b0;
        qd.push_back(2'h3);
        bus_want = 1'b1;
        tick(8);
        for (int c = 0; c < 2; c++) begin
            pa_req = 1'b1;
            dma_req = 2'h1 << c;
            tick(1);
            dma_req = 2'h0;
            tick(5);
            cmp_val(bus.br, 8'h00);
            qd.push_back(2'h1 << c);
            pa_req = 1'b0;
            tick(6);
        end
        cmp_val(8'(qd.size()), 8'h00);
        host_req = 1'b1;
        tick(5);
        cmp_val({host_owns, host_granted, drive_en}, 8'h06);
        host_req = 1'b0;
        tick(3);
        cmp_val({host_owns, host_granted, drive_en}, 8'h01);
        $display("test dma and host done at %0t", $time);
        report_and_stop();
    end
endmodule : test_multiproc_bus_arbitration
